// ### inc/pat_pkg.sv
// Constants, field layout and types of the proximity and ambient tracker
package pat_pkg;

  // ----------------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
  localparam int WAKE_STEP_MS = 200;
  localparam int MS_W = 10;
  localparam int PRE_W = 24;

  // ----------------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------------
  localparam logic [3:0] ADDR_POWER = 4'h0;
  localparam logic [3:0] ADDR_SKIP = 4'h1;
  localparam logic [3:0] ADDR_PROX_CNT = 4'h2;
  localparam logic [3:0] ADDR_AMB_CTRL = 4'h3;
  localparam logic [3:0] ADDR_RECAL = 4'h4;
  localparam logic [3:0] ADDR_RAW = 4'hB;
  localparam logic [3:0] ADDR_STATUS = 4'hC;
  localparam logic [15:0] REG_RESET = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int LOW_PWR_BIT = 0;
  localparam int WAKE_LSB = 2;
  localparam int WAKE_MSB = 3;
  localparam int DECIM_LSB = 8;
  localparam int DECIM_MSB = 9;
  localparam int FF_SKIP_LSB = 0;
  localparam int FF_SKIP_MSB = 3;
  localparam int FP_CNT_LSB = 4;
  localparam int FP_CNT_MSB = 7;
  localparam int LP_CNT_LSB = 8;
  localparam int LP_CNT_MSB = 11;
  localparam int SLOW_FP_LSB = 12;
  localparam int SLOW_FP_MSB = 13;
  localparam int SLOW_LP_LSB = 14;
  localparam int SLOW_LP_MSB = 15;
  localparam int DET_RATE_LSB = 0;
  localparam int DET_RATE_MSB = 7;
  localparam int HOVER_LSB = 8;
  localparam int HOVER_MSB = 13;
  localparam int SLOW_LVL_LSB = 14;
  localparam int SLOW_LVL_MSB = 15;
  localparam int FP_RECAL_LSB = 0;
  localparam int FP_RECAL_MSB = 9;
  localparam int LP_RECAL_LSB = 10;
  localparam int LP_RECAL_MSB = 15;
  localparam int ST_PROX_BIT = 0;
  localparam int ST_CAL_BIT = 1;
  localparam int ST_RECAL_BIT = 2;
  localparam int DECIM_BAD_BIT = 1;

  // ----------------------------------------------------------------------
  // Multipliers and sizes
  // ----------------------------------------------------------------------
  localparam int FP_HOLD_MULT = 16;
  localparam int LP_HOLD_MULT = 4;
  localparam int SLOW_FP_DIV = 4;
  localparam logic [1:0] RECAL_BUSY_SEQS = 2'h2;
  localparam int STAGES = 8;
  localparam int STAGE_W = 3;
  localparam int DATA_W = 16;
  localparam int REC_W = 6 * DATA_W;
  localparam int HOLD_W = 8;
  localparam int RECAL_W = 10;

  // ----------------------------------------------------------------------
  // State types
  // ----------------------------------------------------------------------
  typedef enum logic [0:0] {
    CAL_ON = 1'b0,
    CAL_HOLD = 1'b1
  } pat_cal_type;

  typedef enum logic [0:0] {
    WK_IDLE = 1'b0,
    WK_WAIT = 1'b1
  } pat_wake_type;

  // Per-stage record: ambient, last slow push, fast words 0..3 (0 newest)
  typedef struct packed {
    logic [DATA_W-1:0] ambient;
    logic [DATA_W-1:0] slow_last;
    logic [DATA_W-1:0] w0;
    logic [DATA_W-1:0] w1;
    logic [DATA_W-1:0] w2;
    logic [DATA_W-1:0] w3;
  } pat_rec_type;

endpackage

// ### sim/pat_conv_model.sv
// Converter and sequencer stand-in feeding samples to the tracker
`timescale 1ns/1ns
module pat_conv_model #(
  parameter int NSTG = 2,
  parameter int GAP = 3
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic kick,
  input wire logic seq_start,
  input wire logic [15:0] level,
  output logic sample_valid,
  output logic [2:0] sample_stage,
  output logic [15:0] sample_data,
  output logic seq_done
);
  // ----------------------------------------------------------------
  // One sample per stage, then end of sequence
  // ----------------------------------------------------------------
  logic busy;
  logic hit;
  logic fin;
  int cnt;
  assign hit = en && !rst && busy && cnt % GAP == 0 && cnt < NSTG * GAP;
  assign fin = en && !rst && busy && cnt == NSTG * GAP;
  initial begin
    busy = 1'b0;
    cnt = 0;
    sample_valid = 1'b0;
    sample_stage = 3'h0;
    sample_data = 16'h0000;
    seq_done = 1'b0;
  end
  // Idle data shows the inverse so a stale value never reads as valid
  always @(posedge clk) begin
    sample_valid <= hit;
    sample_stage <= 3'(cnt / GAP);
    sample_data <= hit ? level : ~level;
    seq_done <= fin;
    cnt <= busy ? cnt + 1 : 0;
    if (rst || !en || fin) begin
      busy <= 1'b0;
    end else if (!busy) begin
      busy <= seq_start || kick;
    end
  end
endmodule

// ### sim/pat_tb_top.sv
// Self-checking bench for the proximity and ambient tracker
`timescale 1ns/1ns
module pat_tb_top;
  import pat_pkg::*;
  localparam int CYC = 10;
  logic clk, rst, reg_wr, reg_rd, en, kick, saw_recal;
  logic sample_valid, seq_done, seq_start, prox_detect, cal_enabled;
  logic recal_active, decim_half;
  logic [2:0] sample_stage;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, level, sample_data;
  logic [3:0] addrs [7] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'hB, 4'h7};
  int num_errors, num_checks, cycles, n;

  pat_top #(.CYC_MS(CYC)) uut (
    .clk(clk), .rst(rst), .sample_valid(sample_valid),
    .sample_stage(sample_stage), .sample_data(sample_data),
    .seq_done(seq_done), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .seq_start(seq_start), .prox_detect(prox_detect),
    .cal_enabled(cal_enabled), .recal_active(recal_active),
    .decim_half(decim_half)
  );
  pat_conv_model #(.NSTG(2), .GAP(3)) conv (
    .clk(clk), .rst(rst), .en(en), .kick(kick), .seq_start(seq_start),
    .level(level), .sample_valid(sample_valid),
    .sample_stage(sample_stage), .sample_data(sample_data),
    .seq_done(seq_done)
  );

  // ----------------------------------------------------------------
  // Clock, watchdog and shared tasks
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Ceiling covers about 20000 wake cycles plus about a hundred sequences
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (recal_active === 1'b1) saw_recal <= 1'b1;
    if (cycles == 40000) begin
      num_errors = num_errors + 1;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    check($sformatf("reg %h", a), reg_rdata, exp);
  endtask
  task automatic seqs(input int k);
    repeat (k) begin
      @(posedge clk);
      while (seq_done !== 1'b1) @(posedge clk);
    end
    @(negedge clk);
  endtask
  task automatic flags(input logic p, input logic c);
    check("prox_detect", 16'(prox_detect), 16'(p));
    check("cal_enabled", 16'(cal_enabled), 16'(c));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    en = 1'b0;
    kick = 1'b0;
    saw_recal = 1'b0;
    level = 16'h03E8;
    num_errors = 0;
    num_checks = 0;
    cycles = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    flags(1'b0, 1'b1);
    foreach (addrs[i]) rd_chk(addrs[i], 16'h0000);
    rd_chk(ADDR_STATUS, 16'h0002);
    for (int i = 1; i < 5; i++) begin
      wr(4'(i), 16'hF35A);
      rd_chk(4'(i), 16'hF35A);
    end
    wr(ADDR_RAW, 16'h1234);
    rd_chk(ADDR_RAW, 16'h0000);
    wr(ADDR_POWER, 16'h0100);
    check("decim_half", 16'(decim_half), 16'h0001);
    wr(ADDR_POWER, 16'h0200);
    rd_chk(ADDR_POWER, 16'h0000);
    wr(ADDR_POWER, 16'h0300);
    rd_chk(ADDR_POWER, 16'h0000);
    // Full power, rate 4, hover 63, hold count 1, timeout 50
    wr(ADDR_AMB_CTRL, 16'h3F04);
    wr(ADDR_PROX_CNT, 16'h0010);
    wr(ADDR_RECAL, 16'h0032);
    wr(ADDR_SKIP, 16'h0000);
    @(posedge clk);
    en <= 1'b1;
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    seqs(6);
    rd_chk(ADDR_RAW, 16'h03E8);
    flags(1'b0, 1'b1);
    level <= 16'h044C;
    seqs(4);
    flags(1'b1, 1'b0);
    level <= 16'h03E8;
    seqs(8);
    flags(1'b0, 1'b0);
    seqs(20);
    flags(1'b0, 1'b1);
    level <= 16'h04B0;
    seqs(30);
    flags(1'b1, 1'b0);
    check("early recal", 16'(saw_recal), 16'h0000);
    seqs(30);
    flags(1'b0, 1'b1);
    check("recal seen", 16'(saw_recal), 16'h0001);
    for (int k = 0; k < 4; k++) begin
      wr(ADDR_POWER, 16'(k * 4 + 1));
      @(posedge clk);
      while (seq_done !== 1'b1) @(posedge clk);
      n = 0;
      while (seq_start !== 1'b1) begin
        @(posedge clk);
        n++;
      end
      check("wake", 16'(n), 16'((k + 1) * 200 * CYC + 1));
    end
    stop_test();
  end
endmodule

// ### sim/pat_top_chk.sv
// Port-level assertions for the proximity and ambient tracker
`timescale 1ns/1ns
module pat_top_chk
  import pat_pkg::*;
#(
  parameter int CYC_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [STAGE_W-1:0] sample_stage,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic seq_done,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic seq_start,
  input wire logic prox_detect,
  input wire logic cal_enabled,
  input wire logic recal_active,
  input wire logic decim_half
);
  // ----------------------------------------------------------------
  // Shadow of the low power bit and the latest sample
  // ----------------------------------------------------------------
  typedef struct packed {
    logic lp;
    logic [DATA_W-1:0] raw;
  } pat_chk_type;
  pat_chk_type st_reg;
  pat_chk_type st_next;
  always_comb begin
    st_next = st_reg;
    if (reg_wr && reg_addr == ADDR_POWER) begin
      st_next.lp = reg_wdata[LOW_PWR_BIT];
    end
    if (sample_valid) begin
      st_next.raw = sample_data;
    end
  end
  always_ff @(posedge clk) begin
    st_reg <= rst ? '0 : st_next;
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_fp_done;
    seq_done && !st_reg.lp;
  endsequence
  sequence s_lp_done;
    seq_done && st_reg.lp;
  endsequence
  sequence s_raw_read;
    reg_rd && reg_addr == ADDR_RAW;
  endsequence
  AST_FP_RESTART: assert property (s_fp_done |=> seq_start)
    else $error("full power restart missing");
  AST_LP_WAIT: assert property (s_lp_done |=> !seq_start [*8])
    else $error("low power restart too early");
  AST_DECIM: assert property (reg_wr && reg_addr == ADDR_POWER |=>
    decim_half == ($past(reg_wdata[DECIM_MSB:DECIM_LSB]) == 2'b01))
    else $error("decimation flag wrong");
  AST_RAW_READ: assert property (s_raw_read |=>
    reg_rdata == $past(st_reg.raw))
    else $error("raw result read wrong");
  AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  AST_PROX_HOLDS_CAL: assert property ($rose(prox_detect) |-> !cal_enabled)
    else $error("calibration not held on proximity");
  AST_PROX_FROM_SAMPLE: assert property ($rose(prox_detect) |->
    $past(sample_valid, 2))
    else $error("proximity without a sample");
  AST_CAL_RESUME: assert property ($rose(cal_enabled) |-> !prox_detect)
    else $error("calibration resumed under proximity");
  AST_RECAL_CLEAR: assert property ($rose(recal_active) |->
    ##[0:1] (!prox_detect && cal_enabled))
    else $error("recalibration left proximity set");
endmodule

bind pat_top pat_top_chk #(.CYC_MS(CYC_MS)) u_chk (
  .clk(clk), .rst(rst), .sample_valid(sample_valid),
  .sample_stage(sample_stage), .sample_data(sample_data),
  .seq_done(seq_done), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .seq_start(seq_start), .prox_detect(prox_detect),
  .cal_enabled(cal_enabled), .recal_active(recal_active),
  .decim_half(decim_half)
);

// ### verilog/pat_mem.sv
// Per-stage record memory with registered read data
`timescale 1ns/1ns
module pat_mem
  import pat_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic rd_en,
  input wire logic [STAGE_W-1:0] rd_addr,
  output logic [REC_W-1:0] rd_data,
  input wire logic wr_en,
  input wire logic [STAGE_W-1:0] wr_addr,
  input wire logic [REC_W-1:0] wr_data
);

  logic [REC_W-1:0] mem [STAGES];

  // Contents unknown after reset; the caller tracks which stages are valid
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    if (rst) begin
      rd_data <= '0;
    end else if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ### verilog/pat_top.sv
// Proximity detection and ambient tracking control with register file
// ------------------------------------------------------------------------
// What this block does
// - Low power wake delay code 00..11 gives 200, 400, 600, 800 ms.
// - Low power period is full sequence time then the wake delay.
// - Latest raw 16-bit converter sample readable at index 0x00B.
// - Every stage checked for proximity; detection suspends calibration.
// - Full power hold lasts full-power count times 16 sequences.
// - Low power hold lasts low-power count times 4 sequences.
// - Calibration resumes at hold end only without proximity, else holds.
// - Out of range for whole timeout forces recalibration despite proximity.
// - Full power timeout is 10-bit field times full power sequences.
// - Low power timeout is 6-bit field times low power sequences.
// - Proximity one when fast words one and three differ over rate.
// - Proximity two when fast average and ambient differ over hover.
// - Internal proximity is proximity one or proximity two.
// - Fast skip field sets samples skipped before fast FIFO; 0 none.
// - Slow skip fields for full and low power in ambient skip register.
// - Full power slow interval is skip value times four; 0 acts as 1.
// - Low power slow interval uses low-power skip plus one.
// - Slow push only when sample differs from last push over level.
// - Slow filter updates only when enabled and proximity is clear.
// - Decimation code 00 selects 256, 01 selects 128; others unused.
// ------------------------------------------------------------------------
`timescale 1ns/1ns
module pat_top
  import pat_pkg::*;
#(
  parameter int CYC_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sample_valid,
  input wire logic [STAGE_W-1:0] sample_stage,
  input wire logic [DATA_W-1:0] sample_data,
  input wire logic seq_done,
  input wire logic [3:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic seq_start,
  output logic prox_detect,
  output logic cal_enabled,
  output logic recal_active,
  output logic decim_half
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] power_and_wake_control;
    logic [15:0] ambient_skip_control;
    logic [15:0] proximity_count_control;
    logic [15:0] ambient_control_one;
    logic [15:0] recalibration_timeout;
    logic [15:0] raw_conversion_result;
    logic [15:0] rdata;
    logic p_valid;
    logic [STAGE_W-1:0] p_stage;
    logic [DATA_W-1:0] p_sample;
    logic [STAGES-1:0] stage_ok;
    logic [3:0] ff_cnt;
    logic [3:0] sl_cnt;
    logic fast_slot;
    logic slow_slot;
    logic prox_seq;
    logic oor_seq;
    logic prox_flag;
    pat_cal_type cal_state;
    logic [HOLD_W-1:0] hold_cnt;
    logic [RECAL_W-1:0] recal_cnt;
    logic [1:0] busy_cnt;
    logic recal_apply;
    logic wr_en;
    logic [STAGE_W-1:0] wr_addr;
    logic [REC_W-1:0] wr_data;
  } pat_st_type;

  pat_st_type st_reg;
  pat_st_type st_next;
  logic [REC_W-1:0] rd_data;
  logic tick;

  function automatic logic [DATA_W-1:0] absdiff(input logic [DATA_W-1:0] a,
                                                input logic [DATA_W-1:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  // ----------------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------------
  pat_wake #(
    .CYC_MS(CYC_MS)
  ) u_wake (
    .clk(clk),
    .rst(rst),
    .low_power(st_reg.power_and_wake_control[LOW_PWR_BIT]),
    .wake_delay_sel(st_reg.power_and_wake_control[WAKE_MSB:WAKE_LSB]),
    .seq_done(seq_done),
    .seq_start(tick)
  );

  pat_mem u_mem (
    .clk(clk),
    .rst(rst),
    .rd_en(sample_valid),
    .rd_addr(sample_stage),
    .rd_data(rd_data),
    .wr_en(st_reg.wr_en),
    .wr_addr(st_reg.wr_addr),
    .wr_data(st_reg.wr_data)
  );

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    logic lp;
    logic [3:0] ff_skip;
    logic [1:0] sl_fp;
    logic [3:0] sl_lim;
    logic [HOLD_W-1:0] hold_load;
    logic [RECAL_W-1:0] recal_lim;
    logic [DATA_W-1:0] rate;
    logic [DATA_W-1:0] hover;
    logic [DATA_W-1:0] slow_lvl;
    logic [DATA_W+1:0] sum;
    logic [DATA_W-1:0] avg;
    logic [DATA_W:0] amb_mix;
    logic prox1;
    logic prox2;
    logic next_fast;
    pat_rec_type rec;
    st_next = st_reg;
    next_fast = 1'b0;
    lp = st_reg.power_and_wake_control[LOW_PWR_BIT];
    ff_skip = st_reg.proximity_count_control[FF_SKIP_MSB:FF_SKIP_LSB];
    sl_fp = st_reg.ambient_skip_control[SLOW_FP_MSB:SLOW_FP_LSB];
    rate = DATA_W'(st_reg.ambient_control_one[DET_RATE_MSB:DET_RATE_LSB]);
    hover = DATA_W'(st_reg.ambient_control_one[HOVER_MSB:HOVER_LSB]);
    slow_lvl =
      DATA_W'(st_reg.ambient_control_one[SLOW_LVL_MSB:SLOW_LVL_LSB]);
    // Slow skip limit in fast updates
    if (lp) begin
      sl_lim = 4'(st_reg.ambient_skip_control[SLOW_LP_MSB:SLOW_LP_LSB]);
    end else if (sl_fp == 2'h0) begin
      sl_lim = 4'(SLOW_FP_DIV - 1);
    end else begin
      sl_lim = 4'(int'(sl_fp) * SLOW_FP_DIV - 1);
    end
    if (lp) begin
      hold_load = HOLD_W'(int'(st_reg.proximity_count_control
        [LP_CNT_MSB:LP_CNT_LSB]) * LP_HOLD_MULT);
      recal_lim = RECAL_W'(st_reg.recalibration_timeout
        [LP_RECAL_MSB:LP_RECAL_LSB]);
    end else begin
      hold_load = HOLD_W'(int'(st_reg.proximity_count_control
        [FP_CNT_MSB:FP_CNT_LSB]) * FP_HOLD_MULT);
      recal_lim = st_reg.recalibration_timeout[FP_RECAL_MSB:FP_RECAL_LSB];
    end
    st_next.wr_en = 1'b0;

    // Register port
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_POWER: begin
          st_next.power_and_wake_control = reg_wdata;
          // Unused decimation codes fall back to rate 256
          if (reg_wdata[DECIM_LSB + DECIM_BAD_BIT]) begin
            st_next.power_and_wake_control[DECIM_MSB:DECIM_LSB] = 2'h0;
          end
        end
        ADDR_SKIP: st_next.ambient_skip_control = reg_wdata;
        ADDR_PROX_CNT: st_next.proximity_count_control = reg_wdata;
        ADDR_AMB_CTRL: st_next.ambient_control_one = reg_wdata;
        ADDR_RECAL: st_next.recalibration_timeout = reg_wdata;
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_POWER: st_next.rdata = st_reg.power_and_wake_control;
        ADDR_SKIP: st_next.rdata = st_reg.ambient_skip_control;
        ADDR_PROX_CNT: st_next.rdata = st_reg.proximity_count_control;
        ADDR_AMB_CTRL: st_next.rdata = st_reg.ambient_control_one;
        ADDR_RECAL: st_next.rdata = st_reg.recalibration_timeout;
        ADDR_RAW: st_next.rdata = st_reg.raw_conversion_result;
        ADDR_STATUS: begin
          st_next.rdata = REG_RESET;
          st_next.rdata[ST_PROX_BIT] = st_reg.prox_flag;
          st_next.rdata[ST_CAL_BIT] = (st_reg.cal_state == CAL_ON);
          st_next.rdata[ST_RECAL_BIT] = st_reg.recal_apply;
        end
        default: st_next.rdata = REG_RESET;
      endcase
    end

    // Sequence boundary: timers step once per completed sequence
    if (tick) begin
      next_fast = (st_reg.ff_cnt == ff_skip);
      st_next.ff_cnt = next_fast ? 4'h0 : st_reg.ff_cnt + 4'h1;
      st_next.fast_slot = next_fast;
      st_next.slow_slot = 1'b0;
      if (next_fast) begin
        st_next.slow_slot = (st_reg.sl_cnt >= sl_lim);
        st_next.sl_cnt = (st_reg.sl_cnt >= sl_lim) ? 4'h0
                                                   : st_reg.sl_cnt + 4'h1;
      end
      st_next.prox_flag = st_reg.prox_seq;
      st_next.prox_seq = 1'b0;
      st_next.oor_seq = 1'b0;
      if (st_reg.cal_state == CAL_HOLD) begin
        if (st_reg.hold_cnt <= HOLD_W'(1)) begin
          if (!st_reg.prox_seq) begin
            st_next.cal_state = CAL_ON;
          end else begin
            st_next.hold_cnt = hold_load;
          end
        end else begin
          st_next.hold_cnt = st_reg.hold_cnt - HOLD_W'(1);
        end
      end
      // Busy window keeps a forced recalibration from retriggering
      if (st_reg.busy_cnt != 2'h0) begin
        st_next.busy_cnt = st_reg.busy_cnt - 2'h1;
        st_next.recal_apply = (st_reg.busy_cnt != 2'h1);
        st_next.recal_cnt = '0;
      end else if (st_reg.oor_seq) begin
        if (recal_lim != '0 &&
            st_reg.recal_cnt + RECAL_W'(1) >= recal_lim) begin
          st_next.recal_apply = 1'b1;
          st_next.busy_cnt = RECAL_BUSY_SEQS;
          st_next.recal_cnt = '0;
          st_next.prox_flag = 1'b0;
          st_next.cal_state = CAL_ON;
        end else begin
          st_next.recal_cnt = st_reg.recal_cnt + RECAL_W'(1);
        end
      end else begin
        st_next.recal_cnt = '0;
      end
    end

    // Sample capture, memory read issued in the same cycle
    if (sample_valid) begin
      st_next.raw_conversion_result = sample_data;
      st_next.p_valid = 1'b1;
      st_next.p_stage = sample_stage;
      st_next.p_sample = sample_data;
    end else begin
      st_next.p_valid = 1'b0;
    end

    // Record update; applied after the boundary so a new event wins
    rec = pat_rec_type'(rd_data);
    if (!st_reg.stage_ok[st_reg.p_stage]) begin
      rec = '{default: st_reg.p_sample};
    end
    if (st_reg.fast_slot) begin
      rec.w3 = rec.w2;
      rec.w2 = rec.w1;
      rec.w1 = rec.w0;
      rec.w0 = st_reg.p_sample;
    end
    sum = 18'(rec.w0) + 18'(rec.w1) + 18'(rec.w2) + 18'(rec.w3);
    avg = sum[DATA_W+1:2];
    prox1 = absdiff(rec.w1, rec.w3) > rate;
    prox2 = absdiff(avg, rec.ambient) > hover;
    amb_mix = (17'(rec.ambient) + 17'(st_reg.p_sample)) >> 1;
    if (st_reg.p_valid) begin
      st_next.stage_ok[st_reg.p_stage] = 1'b1;
      if (st_reg.recal_apply) begin
        rec.ambient = avg;
        rec.slow_last = avg;
      end else if (st_reg.slow_slot && st_next.cal_state == CAL_ON &&
                   !st_next.prox_flag && !(prox1 || prox2) &&
                   absdiff(st_reg.p_sample, rec.slow_last) > slow_lvl) begin
        rec.slow_last = st_reg.p_sample;
        rec.ambient = amb_mix[DATA_W-1:0];
      end
      if (prox2) begin
        st_next.oor_seq = 1'b1;
      end
      if ((prox1 || prox2) && !st_reg.recal_apply) begin
        st_next.prox_seq = 1'b1;
        if (!st_next.prox_flag || st_next.cal_state == CAL_ON) begin
          st_next.hold_cnt = hold_load;
        end
        st_next.prox_flag = 1'b1;
        st_next.cal_state = CAL_HOLD;
      end
      st_next.wr_en = 1'b1;
      st_next.wr_addr = st_reg.p_stage;
      st_next.wr_data = REC_W'(rec);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '{cal_state: CAL_ON, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign seq_start = tick;
  assign prox_detect = st_reg.prox_flag;
  assign cal_enabled = (st_reg.cal_state == CAL_ON);
  assign recal_active = st_reg.recal_apply;
  assign decim_half = st_reg.power_and_wake_control[DECIM_LSB];

endmodule

// ### verilog/pat_wake.sv
// Sequence restart timing with the low power wake-up delay
`timescale 1ns/1ns
module pat_wake
  import pat_pkg::*;
#(
  parameter int CYC_MS = CYCLES_PER_MS
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic low_power,
  input wire logic [1:0] wake_delay_sel,
  input wire logic seq_done,
  output logic seq_start
);

  typedef struct packed {
    pat_wake_type state;
    logic [PRE_W-1:0] pre;
    logic [MS_W-1:0] ms;
    logic [MS_W-1:0] target;
    logic start;
  } pat_wk_type;

  pat_wk_type st_reg;
  pat_wk_type st_next;

  always_comb begin
    st_next = st_reg;
    st_next.start = 1'b0;
    unique case (st_reg.state)
      WK_IDLE: begin
        if (seq_done) begin
          if (!low_power) begin
            st_next.start = 1'b1;
          end else begin
            st_next.state = WK_WAIT;
            st_next.pre = '0;
            st_next.ms = '0;
            st_next.target =
              MS_W'(WAKE_STEP_MS * (int'(wake_delay_sel) + 1));
          end
        end
      end
      WK_WAIT: begin
        // Period is sequence time followed by the delay
        if (st_reg.pre == PRE_W'(CYC_MS - 1)) begin
          st_next.pre = '0;
          st_next.ms = st_reg.ms + MS_W'(1);
          if (st_reg.ms + MS_W'(1) == st_reg.target) begin
            st_next.start = 1'b1;
            st_next.state = WK_IDLE;
          end
        end else begin
          st_next.pre = st_reg.pre + PRE_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '{state: WK_IDLE, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign seq_start = st_reg.start;

endmodule
